// ===== sim/hlc_control_sva.sv
// assertions on the ports of the host operating control register
`timescale 1ns/10ps
module hlc_control_sva #(
    parameter SOF_DELAY = 20
) (
    input wire clk,
    input wire reset,
    input wire soft_reset,
    input wire reg_write,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire irq_event,
    input wire resume_detected,
    input wire frame_start,
    input wire iso_descriptor,
    input wire host_irq,
    input wire mgmt_irq,
    input wire wake_request,
    input wire frame_start_flag,
    input wire port_reset_drive,
    input wire periodic_go,
    input wire iso_go,
    input wire control_go,
    input wire bulk_go,
    input wire pick_control
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] since_wr;
    // saturating age of the last control write, to time the frame start
    always @(posedge clk)
    begin
        if (reset || (reg_write && reg_addr == 8'h04))
            since_wr <= 16'h0;
        else if (since_wr != 16'hffff)
            since_wr <= since_wr + 16'h1;
    end
    a_write_readback: assert property (reg_write && reg_addr == 8'h04 && !soft_reset
        ##1 !reg_write && !soft_reset |-> ##1 {reg_rdata[10:8], reg_rdata[5:0]}
        == {$past(reg_wdata[10:8], 2), $past(reg_wdata[5:0], 2)}) else $error("readback wrong");
    a_upper_zero: assert property (reg_rdata[31:11] == 21'h0) else $error("upper bits set");
    a_irq_exclusive: assert property (!(host_irq && mgmt_irq)) else $error("both irqs");
    a_irq_cause: assert property (host_irq || mgmt_irq |-> $past(irq_event))
        else $error("irq without event");
    a_wake_cause: assert property (wake_request |-> $past(resume_detected))
        else $error("wake without resume");
    a_port_reset: assert property ($fell(reset) |=> port_reset_drive)
        else $error("no port reset");
    a_go_hold: assert property (!$stable({periodic_go, iso_go, control_go, bulk_go})
        |-> $past(frame_start) || $past(soft_reset) || $past(reset)
        || ($past(iso_descriptor) && $fell(periodic_go) && $stable({iso_go, control_go, bulk_go})))
        else $error("enable moved mid frame");
    a_iso_halt: assert property (iso_descriptor && !iso_go && !frame_start && !soft_reset
        |=> !periodic_go) else $error("periodic kept after iso");
    a_pick_gate: assert property (pick_control |-> $past(control_go))
        else $error("control picked while disabled");
    a_sof_delay: assert property ($rose(frame_start_flag) |-> since_wr >= SOF_DELAY - 2)
        else $error("frames began early");
    a_soft_suspend: assert property (soft_reset ##1 !soft_reset && !reg_write
        |-> ##1 reg_rdata[7:6] == 2'h3) else $error("soft reset not suspend");
    c_frames: cover property ($rose(frame_start_flag));
    c_mgmt: cover property (mgmt_irq);
    c_wake: cover property (wake_request);
    c_bulk_turn: cover property (control_go && !pick_control);
endmodule
bind hlc_control hlc_control_sva #(.SOF_DELAY(SOF_DELAY)) i_hlc_control_sva (.*);

// ===== sim/hlc_control_test.sv
// self-checking bench for the host operating control register
`timescale 1ns/10ps
module hlc_control_test;
    localparam int SOF = 20;
    logic clk = 0, reset = 1, soft_reset = 0, reg_write = 0, irq_event = 0;
    logic resume_detected = 0, port_resume_pin = 0, frame_start = 0, iso_descriptor = 0;
    logic control_served = 0;
    logic [7:0] reg_addr = 8'h04;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic host_irq, mgmt_irq, wake_request, frame_start_flag, port_reset_drive;
    logic periodic_go, iso_go, control_go, bulk_go, pick_control;
    int n_errors = 0, num_checks = 0, i, k;
    hlc_control #(.SOF_DELAY(SOF)) i_hlc_control (.*);
    always #25 clk = ~clk;
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe, returns once the readback has landed
    task wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_write = 1;
        step(1);
        reg_write = 0;
        step(1);
    endtask
    // a frame start, optionally with a served control descriptor
    task frame(input logic served);
        frame_start = 1;
        control_served = served;
        step(1);
        frame_start = 0;
        control_served = 0;
        step(1);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        d = $urandom(32'hcde2);
        step(10);
        reset = 0;
        step(1);
        chk(reg_rdata, 32'h0);
        chk(port_reset_drive, 1'b1);
        // state kept at reset so the frame timer stays idle
        for (i = 0; i < 8; i++)
        begin
            d = $urandom & 32'h73f;
            wr(8'h04, d);
            chk(reg_rdata, d);
            irq_event = 1;
            resume_detected = 1;
            frame(0);
            chk({host_irq, mgmt_irq}, {!d[8], d[8]});
            chk(wake_request, d[10]);
            chk({periodic_go, iso_go, control_go, bulk_go}, {d[2], d[3], d[4], d[5]});
            irq_event = 0;
            resume_detected = 0;
        end
        wr(8'h04, d ^ 32'h3c);
        chk({periodic_go, iso_go, control_go, bulk_go}, {d[2], d[3], d[4], d[5]});
        // iso descriptor halts periodic only while iso is disabled
        for (i = 0; i < 2; i++)
        begin
            wr(8'h04, 32'h4 | (i << 3));
            frame(0);
            iso_descriptor = 1;
            step(1);
            iso_descriptor = 0;
            chk(periodic_go, i);
        end
        for (k = 0; k < 4; k++)
        begin
            reset = 1;
            step(1);
            reset = 0;
            wr(8'h04, 32'h10 | k);
            frame(0);
            for (i = 0; i <= k; i++)
            begin
                chk(pick_control, 1'b1);
                frame(1);
            end
            chk(pick_control, 1'b0);
        end
        wr(8'h04, 32'h324);
        soft_reset = 1;
        step(1);
        soft_reset = 0;
        step(2);
        chk(reg_rdata, 32'h3c0);
        port_resume_pin = 1;
        step(6);
        chk(reg_rdata[7:6], 2'h1);
        port_resume_pin = 0;
        reset = 1;
        step(1);
        reset = 0;
        step(2);
        chk(reg_rdata, 32'h0);
        wr(8'h04, 32'h80);
        step(SOF - 4);
        chk(frame_start_flag, 1'b0);
        for (i = 0; i < 10 && frame_start_flag !== 1'b1; i++)
            step(1);
        chk(frame_start_flag, 1'b1);
        wr(8'h0c, 32'h4);
        chk(frame_start_flag, 1'b0);
        wr(8'h08, 32'hffffffff);
        chk(reg_rdata, 32'h80);
        end_sim;
    end
endmodule

// ===== verilog/hlc_control.v
// host operating control register with list gating and service arbitration
`timescale 1ns/10ps
`include "hlc_defs.vh"
// Operation
// - wakeup connected flag cleared by hardware reset, kept on software reset.
// - routing bit low sends events to host interrupt, high to management.
// - routing bit cleared by hardware reset, kept across software reset.
// - functional state codes: reset 00, resume 01, operational 10, suspend 11.
// - entering operational starts frame generation one millisecond later.
// - frame start flag reports that frame generation has begun.
// - hardware changes state only in suspend, may go to resume.
// - software reset gives suspend; hardware reset gives reset plus port reset.
// - bulk list served next frame only when its enable is set.
// - control list served next frame only when its enable is set.
// - isochronous descriptor continues if enabled, else periodic halts.
// - isochronous enable changes apply from the following frame.
// - periodic list served next frame only when its enable is set.
// - control count compared with ratio to pick control or bulk.
// - control served count kept across frame boundaries.
// - wake request when wake enable and resume detected both set.
module hlc_control #(
    parameter SOF_DELAY = `HLC_SOF_DELAY_CYCLES
) (
    input wire clk,
    input wire reset,
    input wire soft_reset,
    input wire reg_write,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    input wire irq_event,
    input wire resume_detected,
    input wire port_resume_pin,
    input wire frame_start,
    input wire iso_descriptor,
    input wire control_served,
    output reg host_irq,
    output reg mgmt_irq,
    output reg wake_request,
    output reg frame_start_flag,
    output reg port_reset_drive,
    output reg periodic_go,
    output reg iso_go,
    output reg control_go,
    output reg bulk_go,
    output reg pick_control
);
    reg wakeup_enable_flag;
    reg wakeup_connected_flag;
    reg interrupt_routing_select;
    reg [1:0] functional_state_field;
    reg bulk_list_enable;
    reg isochronous_enable;
    reg control_list_enable;
    reg periodic_list_enable;
    reg [1:0] service_ratio_field;
    reg [2:0] control_count;
    reg [22:0] sof_timer;
    reg sof_pending;
    reg frame_start_flag_clr;
    wire port_resume;
    wire hit;
    wire [1:0] wstate;
    wire [31:0] next_rdata;

    // resume pin comes from the port domain
    hlc_sync #(
        .WIDTH(1)
    ) u_resume_sync (
        .clk(clk),
        .reset(reset),
        .async_in(port_resume_pin),
        .sync_out(port_resume)
    );

    assign hit = reg_write && (reg_addr == `HLC_OFFSET);
    assign wstate = reg_wdata[`HLC_BIT_STATE_HI:`HLC_BIT_STATE_LO];

    // register fields; software reset spares routing and connected bits
    always @(posedge clk)
    begin
        if (reset)
        begin
            wakeup_enable_flag <= 1'b0;
            wakeup_connected_flag <= 1'b0;
            interrupt_routing_select <= 1'b0;
            functional_state_field <= `HLC_STATE_RESET;
            bulk_list_enable <= 1'b0;
            isochronous_enable <= 1'b0;
            control_list_enable <= 1'b0;
            periodic_list_enable <= 1'b0;
            service_ratio_field <= 2'h0;
        end
        else if (soft_reset)
        begin
            wakeup_enable_flag <= 1'b0;
            functional_state_field <= `HLC_STATE_SUSPEND;
            bulk_list_enable <= 1'b0;
            isochronous_enable <= 1'b0;
            control_list_enable <= 1'b0;
            periodic_list_enable <= 1'b0;
            service_ratio_field <= 2'h0;
        end
        else if (hit)
        begin
            wakeup_enable_flag <= reg_wdata[`HLC_BIT_WAKE_EN];
            wakeup_connected_flag <= reg_wdata[`HLC_BIT_CONNECTED];
            interrupt_routing_select <= reg_wdata[`HLC_BIT_ROUTING];
            functional_state_field <= wstate;
            bulk_list_enable <= reg_wdata[`HLC_BIT_BULK];
            isochronous_enable <= reg_wdata[`HLC_BIT_ISO];
            control_list_enable <= reg_wdata[`HLC_BIT_CONTROL];
            periodic_list_enable <= reg_wdata[`HLC_BIT_PERIODIC];
            service_ratio_field <= reg_wdata[`HLC_BIT_RATIO_HI:`HLC_BIT_RATIO_LO];
        end
        else if (functional_state_field == `HLC_STATE_SUSPEND && port_resume)
        begin
            functional_state_field <= `HLC_STATE_RESUME;
        end
    end

    // one millisecond wait before frames start on entry to operational
    always @(posedge clk)
    begin
        if (reset || soft_reset)
        begin
            sof_timer <= 23'h000000;
            sof_pending <= 1'b0;
            frame_start_flag <= 1'b0;
        end
        else
        begin
            if (hit && wstate == `HLC_STATE_OPERATIONAL
                && functional_state_field != `HLC_STATE_OPERATIONAL)
            begin
                sof_timer <= SOF_DELAY[22:0];
                sof_pending <= 1'b1;
            end
            else if (hit && wstate != `HLC_STATE_OPERATIONAL)
            begin
                sof_pending <= 1'b0;
            end
            else if (sof_pending && sof_timer > 23'h000001)
            begin
                sof_timer <= sof_timer - 23'h000001;
            end
            else if (sof_pending)
            begin
                sof_pending <= 1'b0;
            end
            // set beats clear when both land together
            if (sof_pending && sof_timer == 23'h000001)
                frame_start_flag <= 1'b1;
            else if (frame_start_flag_clr)
                frame_start_flag <= 1'b0;
        end
    end

    // flag is write-one-to-clear through bit 2 of a status write
    always @*
    begin
        frame_start_flag_clr = reg_write && (reg_addr == `HLC_STATUS_OFFSET)
            && reg_wdata[`HLC_BIT_FRAME_CLR];
    end

    // list enables sampled once per frame so mid-frame writes wait
    always @(posedge clk)
    begin
        if (reset || soft_reset)
        begin
            periodic_go <= 1'b0;
            iso_go <= 1'b0;
            control_go <= 1'b0;
            bulk_go <= 1'b0;
        end
        else if (frame_start)
        begin
            periodic_go <= periodic_list_enable;
            iso_go <= isochronous_enable;
            control_go <= control_list_enable;
            bulk_go <= bulk_list_enable;
        end
        else if (iso_descriptor && !iso_go)
        begin
            periodic_go <= 1'b0;
        end
    end

    // control count survives frame starts; reset, soft reset and the ratio wrap clear it
    // after ratio+1 served control descriptors bulk gets one cycle of turn
    always @(posedge clk)
    begin
        if (reset || soft_reset)
        begin
            control_count <= 3'h0;
            pick_control <= 1'b0;
        end
        else
        begin
            if (control_count > {1'b0, service_ratio_field})
                control_count <= 3'h0;
            else if (control_served)
                control_count <= control_count + 3'h1;
            pick_control <= control_go && (control_count <= {1'b0, service_ratio_field});
        end
    end

    // interrupt routing, wake request, port reset and read data
    assign next_rdata = {21'h000000, wakeup_enable_flag, wakeup_connected_flag,
        interrupt_routing_select, functional_state_field, bulk_list_enable,
        control_list_enable, isochronous_enable, periodic_list_enable,
        service_ratio_field};

    always @(posedge clk)
    begin
        if (reset)
        begin
            host_irq <= 1'b0;
            mgmt_irq <= 1'b0;
            wake_request <= 1'b0;
            port_reset_drive <= 1'b0;
            reg_rdata <= `HLC_RESET_VALUE;
        end
        else
        begin
            host_irq <= irq_event && !interrupt_routing_select;
            mgmt_irq <= irq_event && interrupt_routing_select;
            wake_request <= wakeup_enable_flag && resume_detected;
            port_reset_drive <= (functional_state_field == `HLC_STATE_RESET);
            reg_rdata <= next_rdata;
        end
    end
endmodule

// ===== verilog/hlc_defs.vh
// constants for the host operating control register block
`ifndef HLC_DEFS_VH
`define HLC_DEFS_VH
`define HLC_OFFSET 8'h04
`define HLC_STATUS_OFFSET 8'h0c
`define HLC_BIT_FRAME_CLR 2
`define HLC_BIT_RATIO_LO 0
`define HLC_BIT_RATIO_HI 1
`define HLC_BIT_PERIODIC 2
`define HLC_BIT_ISO 3
`define HLC_BIT_CONTROL 4
`define HLC_BIT_BULK 5
`define HLC_BIT_STATE_LO 6
`define HLC_BIT_STATE_HI 7
`define HLC_BIT_ROUTING 8
`define HLC_BIT_CONNECTED 9
`define HLC_BIT_WAKE_EN 10
`define HLC_RESET_VALUE 32'h00000000
`define HLC_STATE_RESET 2'h0
`define HLC_STATE_RESUME 2'h1
`define HLC_STATE_OPERATIONAL 2'h2
`define HLC_STATE_SUSPEND 2'h3
`define HLC_SOF_DELAY_NS 1000000
`define HLC_CLK_PERIOD_NS 50
`define HLC_SOF_DELAY_CYCLES (`HLC_SOF_DELAY_NS / `HLC_CLK_PERIOD_NS)
`endif

// ===== verilog/hlc_sync.v
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module hlc_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire reset,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always @(posedge clk)
    begin
        if (reset)
        begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
